/* rtl/stc_counter.sv */
`timescale 1ns/10ps
module stc_counter
  import stc_pkg::*;
#(
  parameter int W = STC_CNT_W
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic step_i,
  input wire logic clear_i,
  input wire logic [W-1:0] reload_val_i,
  // Status
  output logic [W-1:0] count_o,
  output logic zero_step_o
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  // Clear wins over a step so a write never raises a zero step
  assign zero_step_o = step_i && !clear_i && (count_q == W'(1));

  always_comb
  begin
    count_d = count_q;
    if (clear_i)
    begin
      count_d = '0;
    end
    else if (step_i)
    begin
      if (count_q == '0)
      begin
        // Zero reload keeps the count parked at zero
        count_d = reload_val_i;
      end
      else
      begin
        count_d = count_q - W'(1);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      count_q <= STC_CNT_RESET;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign count_o = count_q;

endmodule

/* rtl/stc_pkg.sv */
package stc_pkg;

  // Register byte addresses
  localparam logic [31:0] STC_ADDR_CTRL   = 32'hE000E010;
  localparam logic [31:0] STC_ADDR_RELOAD = 32'hE000E014;
  localparam logic [31:0] STC_ADDR_CURR   = 32'hE000E018;
  localparam logic [31:0] STC_ADDR_CALIB  = 32'hE000E01C;
  localparam logic [31:0] STC_ADDR_IRQ_ST = 32'hE000E020;
  localparam logic [31:0] STC_ADDR_IRQ_CL = 32'hE000E024;
  localparam logic [31:0] STC_ADDR_IRQ_EN = 32'hE000E028;

  // Field layout
  localparam int STC_CNT_W         = 24;
  localparam int STC_BIT_ENABLE    = 0;
  localparam int STC_BIT_TICK_IRQ_EN = 1;
  localparam int STC_BIT_CLKSEL    = 2;
  localparam int STC_BIT_ZFLAG     = 16;
  localparam int STC_EVT_W         = 2;
  localparam int STC_EVT_ZERO      = 0;
  localparam int STC_EVT_CURR_CLR  = 1;

  // Reset and fixed values
  localparam logic [31:0] STC_CTRL_RESET  = 32'h00000000;
  localparam logic [23:0] STC_CNT_RESET   = 24'h000000;
  localparam logic [31:0] STC_CALIB_VALUE = 32'h00000004;
  localparam logic [1:0]  STC_EVT_RESET   = 2'h0;

  typedef struct packed {
    logic tick_irq_enable;
    logic enable;
  } stc_ctrl_t;

  localparam stc_ctrl_t STC_CTRL_FIELDS_RESET = '{tick_irq_enable: 1'b0, enable: 1'b0};

endpackage

/* rtl/stc_tick_timer.sv */
// Behaviour
// - While enabled, count down; at zero reload on next edge, continue decrementing.
// - Set the zero-reached flag whenever the count steps to zero.
// - Control bit 16 returns the flag since last read; reading clears it.
// - Reload value zero parks the counter at zero while still enabled.
// - Any current-value write clears the count and the zero-reached flag.
// - After that write reload on the next tick, without an exception request.
// - Current-value read returns the count at the moment of access.
// - Counting stops while the debugger halts the processor.
// - Clock-select bit always reads one; writes to it are ignored.
// - Tick interrupt enable bit gates the exception request.
// - Reload register holds 24 bits, loaded into the count only at zero.
// - The zero event fires only on the step from one to zero; a current-value write sets the clear event.
// - Counting follows the interrupt controller clock and stops when gated.
`timescale 1ns/10ps
module stc_tick_timer
  import stc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Core state
  input wire logic debug_halt_i,
  input wire logic irq_clk_en_i,
  // Requests
  output logic tick_req_o,
  output logic irq_o
);

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  logic wr_ctrl;
  logic rd_ctrl;
  logic wr_reload;
  logic wr_curr;
  logic wr_irq_cl;
  logic wr_irq_en;

  assign wr_ctrl = wr_i && hit(addr_i, STC_ADDR_CTRL);
  assign rd_ctrl = rd_i && hit(addr_i, STC_ADDR_CTRL);
  assign wr_reload = wr_i && hit(addr_i, STC_ADDR_RELOAD);
  assign wr_curr = wr_i && hit(addr_i, STC_ADDR_CURR);
  assign wr_irq_cl = wr_i && hit(addr_i, STC_ADDR_IRQ_CL);
  assign wr_irq_en = wr_i && hit(addr_i, STC_ADDR_IRQ_EN);

  // Register state
  stc_ctrl_t ctrl_q;
  stc_ctrl_t ctrl_d;
  logic [STC_CNT_W-1:0] reload_q;
  logic [STC_CNT_W-1:0] reload_d;
  logic zflag_q;
  logic zflag_d;
  logic [STC_EVT_W-1:0] evt_st_q;
  logic [STC_EVT_W-1:0] evt_st_d;
  logic [STC_EVT_W-1:0] evt_en_q;
  logic [STC_EVT_W-1:0] evt_en_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic tick_req_q;
  logic tick_req_d;
  logic irq_q;
  logic irq_d;

  logic step;
  logic zero_step;
  logic [STC_CNT_W-1:0] count;
  logic [STC_EVT_W-1:0] evt_set;

  // Debug halt and gated controller clock both freeze the count
  assign step = ctrl_q.enable && !debug_halt_i && irq_clk_en_i;

  stc_counter #(
    .W(STC_CNT_W)
  ) u_counter (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .step_i(step),
    .clear_i(wr_curr),
    .reload_val_i(reload_q),
    .count_o(count),
    .zero_step_o(zero_step)
  );

  always_comb
  begin
    evt_set = '0;
    evt_set[STC_EVT_ZERO] = zero_step;
    evt_set[STC_EVT_CURR_CLR] = wr_curr;
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    reload_d = reload_q;
    zflag_d = zflag_q;
    evt_en_d = evt_en_q;
    if (wr_ctrl)
    begin
      // Clock select and reserved bits are not stored
      ctrl_d.enable = wdata_i[STC_BIT_ENABLE];
      ctrl_d.tick_irq_enable = wdata_i[STC_BIT_TICK_IRQ_EN];
    end
    if (wr_reload)
    begin
      reload_d = wdata_i[STC_CNT_W-1:0];
    end
    if (wr_irq_en)
    begin
      evt_en_d = wdata_i[STC_EVT_W-1:0];
    end
    // Read or write clears, a fresh zero step wins
    if (rd_ctrl || wr_curr)
    begin
      zflag_d = 1'b0;
    end
    if (zero_step)
    begin
      zflag_d = 1'b1;
    end
    // Set wins over clear for the sticky status
    evt_st_d = (evt_st_q & ~(wr_irq_cl ? wdata_i[STC_EVT_W-1:0] : STC_EVT_RESET)) | evt_set;
  end

  always_comb
  begin
    rdata_d = '0;
    if (rd_i)
    begin
      unique case (1'b1)
        hit(addr_i, STC_ADDR_CTRL):
        begin
          rdata_d[STC_BIT_ENABLE] = ctrl_q.enable;
          rdata_d[STC_BIT_TICK_IRQ_EN] = ctrl_q.tick_irq_enable;
          rdata_d[STC_BIT_CLKSEL] = 1'b1;
          rdata_d[STC_BIT_ZFLAG] = zflag_q;
        end
        hit(addr_i, STC_ADDR_RELOAD):
        begin
          rdata_d[STC_CNT_W-1:0] = reload_q;
        end
        hit(addr_i, STC_ADDR_CURR):
        begin
          rdata_d[STC_CNT_W-1:0] = count;
        end
        hit(addr_i, STC_ADDR_CALIB):
        begin
          rdata_d = STC_CALIB_VALUE;
        end
        hit(addr_i, STC_ADDR_IRQ_ST):
        begin
          rdata_d[STC_EVT_W-1:0] = evt_st_q;
        end
        hit(addr_i, STC_ADDR_IRQ_EN):
        begin
          rdata_d[STC_EVT_W-1:0] = evt_en_q;
        end
        default:
        begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_comb
  begin
    // Pulse per zero step; the clear-by-write path never reaches it
    tick_req_d = zero_step && ctrl_q.tick_irq_enable;
    irq_d = |(evt_st_q & evt_en_q);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= STC_CTRL_FIELDS_RESET;
      reload_q <= STC_CNT_RESET;
      zflag_q <= 1'b0;
      evt_st_q <= STC_EVT_RESET;
      evt_en_q <= STC_EVT_RESET;
      rdata_q <= STC_CTRL_RESET;
      tick_req_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      reload_q <= reload_d;
      zflag_q <= zflag_d;
      evt_st_q <= evt_st_d;
      evt_en_q <= evt_en_d;
      rdata_q <= rdata_d;
      tick_req_q <= tick_req_d;
      irq_q <= irq_d;
    end
  end

  assign rdata_o = rdata_q;
  assign tick_req_o = tick_req_q;
  assign irq_o = irq_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_zero_evt;
    zero_step && ctrl_q.tick_irq_enable;
  endsequence

  sequence s_pulse;
    tick_req_o ##1 !tick_req_o;
  endsequence

  property p_decrement;
    step && !wr_curr && count != '0 |=> count == $past(count) - 24'h000001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("count did not decrement");

  property p_wrap;
    step && !wr_curr && count == '0 |=> count == $past(reload_q);
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not reload at zero");

  property p_flag_set;
    zero_step |=> zflag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("zero flag not set");

  property p_read_clear;
    rd_ctrl && !zero_step |=> rdata_o[STC_BIT_ZFLAG] == $past(zflag_q) && !zflag_q;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag read or clear wrong");

  property p_curr_write;
    wr_curr |=> count == '0 && !zflag_q && !tick_req_o;
  endproperty
  a_curr_write: assert property (p_curr_write) else $error("current write misbehaved");

  property p_park;
    step && count == '0 && reload_q == '0 |=> count == '0 && !tick_req_o;
  endproperty
  a_park: assert property (p_park) else $error("zero reload not parked");

  property p_halt;
    debug_halt_i && !wr_curr |=> $stable(count);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved while halted");

  property p_clk_sel;
    rd_ctrl |=> rdata_o[STC_BIT_CLKSEL] && rdata_o[15:3] == '0 && rdata_o[31:17] == '0;
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("control read bits wrong");

  property p_req_cause;
    tick_req_o |-> $past(ctrl_q.tick_irq_enable) && $past(count) == 24'h000001;
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("request without cause");

  property p_req_pulse;
    s_zero_evt |=> s_pulse;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request not a pulse");

  property p_cur_read;
    rd_i && hit(addr_i, STC_ADDR_CURR) |=> rdata_o == {8'h00, $past(count)};
  endproperty
  a_cur_read: assert property (p_cur_read) else $error("current read wrong");

  property p_irq_level;
    ##1 irq_o == $past(|(evt_st_q & evt_en_q));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  property p_no_req;
    zero_step && !ctrl_q.tick_irq_enable |=> !tick_req_o;
  endproperty
  a_no_req: assert property (p_no_req) else $error("request while disabled");

  property p_gate;
    !irq_clk_en_i && !wr_curr |=> $stable(count);
  endproperty
  a_gate: assert property (p_gate) else $error("count moved while gated");

  // Reload follows the clear only once the next step comes
  sequence s_curr_clear;
    wr_curr ##1 (step && !wr_curr);
  endsequence

  property p_curr_reload;
    s_curr_clear |=> count == $past(reload_q) && !tick_req_o;
  endproperty
  a_curr_reload: assert property (p_curr_reload) else $error("no reload after clear");

  property p_reload_read;
    rd_i && hit(addr_i, STC_ADDR_RELOAD) |=> rdata_o[31:24] == 8'h00;
  endproperty
  a_reload_read: assert property (p_reload_read) else $error("reload reserved bits set");

endmodule

/* sim/stc_intc_model.sv */
`timescale 1ns/10ps
module stc_intc_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Request from the timer
  input wire logic tick_req_i,
  // Observation
  output int pulses_o,
  output logic long_o
);
  logic last_q;

  // A request held two cycles would be taken twice by the controller
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pulses_o <= 0;
      long_o <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      last_q <= tick_req_i;
      if (tick_req_i && !last_q)
        pulses_o <= pulses_o + 1;
      if (tick_req_i && last_q)
        long_o <= 1'b1;
    end
  end
endmodule

/* sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import stc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [31:0] addr_i = 32'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic debug_halt_i = 1'b0;
  logic irq_clk_en_i = 1'b1;
  logic [31:0] rdata_o;
  logic tick_req_o;
  logic irq_o;
  logic long_o;
  logic [31:0] a;
  logic [31:0] b;
  int pulses_o;
  int n_fail = 0;
  int checked = 0;
  int n;
  int p;

  always #5 clk_i = ~clk_i;

  stc_tick_timer dut_u (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .debug_halt_i(debug_halt_i),
    .irq_clk_en_i(irq_clk_en_i), .tick_req_o(tick_req_o), .irq_o(irq_o));

  stc_intc_model intc_u (.clk_i(clk_i), .reset_i(reset_i), .tick_req_i(tick_req_o),
    .pulses_o(pulses_o), .long_o(long_o));

  task finish_test();
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task wr(input logic [31:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task rd(input logic [31:0] ad, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task rdc(input logic [31:0] ad, input logic [31:0] e);
    logic [31:0] d;
    rd(ad, d);
    chk(d, e);
  endtask

  task wait_tick();
    int i;
    for (i = 0; i < 300 && tick_req_o !== 1'b1; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    if (tick_req_o !== 1'b1)
    begin
      n_fail++;
      finish_test();
    end
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    rdc(STC_ADDR_CTRL, 32'h00000004);
    rdc(STC_ADDR_CALIB, 32'h00000004);
    rdc(32'hE000E030, 32'h00000000);
    wr(STC_ADDR_CALIB, 32'hFFFFFFFF);
    rdc(STC_ADDR_CALIB, 32'h00000004);
    wr(STC_ADDR_RELOAD, 32'hFF000003);
    rdc(STC_ADDR_RELOAD, 32'h00000003);
    wr(STC_ADDR_CTRL, 32'hFFFEFFF8);
    rdc(STC_ADDR_CTRL, 32'h00000004);
    wr(STC_ADDR_CURR, 32'h00000000);
    rdc(STC_ADDR_IRQ_ST, 32'h00000002);
    wr(STC_ADDR_IRQ_CL, 32'h00000003);
    wr(STC_ADDR_IRQ_EN, 32'h00000001);
    wr(STC_ADDR_CTRL, 32'h00000003);
    wait_tick();
    // Reload of 3 repeats every 4 cycles
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    while (tick_req_o !== 1'b1 && n < 50);
    chk(n, 4);
    wr(STC_ADDR_CTRL, 32'h00000002);
    rdc(STC_ADDR_CTRL, 32'h00010006);
    rdc(STC_ADDR_CTRL, 32'h00000006);
    chk(irq_o, 1'b1);
    rdc(STC_ADDR_IRQ_ST, 32'h00000001);
    wr(STC_ADDR_IRQ_CL, 32'h00000001);
    @(posedge clk_i);
    #1;
    chk(irq_o, 1'b0);
    wr(STC_ADDR_CTRL, 32'h00000003);
    wait_tick();
    wr(STC_ADDR_CTRL, 32'h00000002);
    wr(STC_ADDR_CURR, 32'hFFFFFFFF);
    rdc(STC_ADDR_CURR, 32'h00000000);
    rdc(STC_ADDR_CTRL, 32'h00000006);
    p = pulses_o;
    wr(STC_ADDR_CTRL, 32'h00000001);
    repeat (12) @(posedge clk_i);
    wr(STC_ADDR_CTRL, 32'h00000000);
    #1;
    chk(pulses_o, p);
    rdc(STC_ADDR_CTRL, 32'h00010004);
    wr(STC_ADDR_RELOAD, 32'h00000000);
    wr(STC_ADDR_CURR, 32'h00000000);
    wr(STC_ADDR_CTRL, 32'h00000003);
    repeat (20) @(posedge clk_i);
    #1;
    chk(pulses_o, p);
    rdc(STC_ADDR_CURR, 32'h00000000);
    rdc(STC_ADDR_CTRL, 32'h00000007);
    wr(STC_ADDR_RELOAD, 32'h00000064);
    for (int k = 0; k < 2; k++)
    begin
      repeat (5) @(posedge clk_i);
      debug_halt_i <= (k == 0);
      irq_clk_en_i <= (k == 0);
      repeat (2) @(posedge clk_i);
      rd(STC_ADDR_CURR, a);
      repeat (10) @(posedge clk_i);
      rd(STC_ADDR_CURR, b);
      chk(b, a);
      @(posedge clk_i);
      debug_halt_i <= 1'b0;
      irq_clk_en_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(STC_ADDR_CURR, b);
      chk(b, a - 32'h00000004);
    end
    wr(STC_ADDR_CURR, 32'h00000005);
    rdc(STC_ADDR_CURR, 32'h00000064);
    chk(long_o, 1'b0);
    finish_test();
  end
endmodule
